// ---- hw/smt_pkg.sv ----
package smt_pkg;

    // register map
    localparam logic [7:0] SMT_OFS_CFG_A = 8'h14;
    localparam logic [7:0] SMT_OFS_CFG_B = 8'h15;
    localparam logic [7:0] SMT_OFS_CFG_C = 8'h16;
    localparam logic [7:0] SMT_CFG_RESET = 8'h00;
    localparam logic [7:0] SMT_RD_UNMAPPED = 8'h00;

    // field positions
    localparam int SMT_MON_TOL_LSB = 3;
    localparam int SMT_MON_LVL_LSB = 0;
    localparam int SMT_RSVD_LSB = 5;
    localparam int SMT_ANA_TOL_LSB = 6;
    localparam int SMT_ANA_LVL_BIT = 5;
    localparam int SMT_BOOST_TOL_LSB = 6;
    localparam int SMT_BOOST_LVL_LSB = 4;
    localparam int SMT_STEPB_TOL_LSB = 2;
    localparam int SMT_STEPA_TOL_LSB = 0;

    // tolerances in tenths of a percent
    localparam logic [7:0] SMT_TOL_2P0 = 8'h14;
    localparam logic [7:0] SMT_TOL_3P0 = 8'h1E;
    localparam logic [7:0] SMT_TOL_4P0 = 8'h28;
    localparam logic [7:0] SMT_TOL_5P0 = 8'h32;
    localparam logic [7:0] SMT_TOL_6P0 = 8'h3C;
    localparam logic [7:0] SMT_TOL_8P0 = 8'h50;
    localparam logic [7:0] SMT_TOL_10P0 = 8'h64;

    // step-down absolute windows in mV
    localparam logic [6:0] SMT_STEP_TOL_30MV = 7'h1E;
    localparam logic [6:0] SMT_STEP_TOL_50MV = 7'h32;
    localparam logic [6:0] SMT_STEP_TOL_70MV = 7'h46;
    localparam logic [6:0] SMT_STEP_TOL_90MV = 7'h5A;

    // monitor nominal levels in mV
    localparam logic [11:0] SMT_LVL_650MV = 12'h28A;
    localparam logic [11:0] SMT_LVL_800MV = 12'h320;
    localparam logic [11:0] SMT_LVL_1000MV = 12'h3E8;
    localparam logic [11:0] SMT_LVL_1100MV = 12'h44C;
    localparam logic [11:0] SMT_LVL_1200MV = 12'h4B0;
    localparam logic [11:0] SMT_LVL_1300MV = 12'h514;
    localparam logic [11:0] SMT_LVL_1800MV = 12'h708;
    localparam logic [11:0] SMT_LVL_UNDEF = 12'h000;

    // analog supply nominal levels in mV
    localparam logic [12:0] SMT_ANA_3300MV = 13'h0CE4;
    localparam logic [12:0] SMT_ANA_5000MV = 13'h1388;

    function automatic logic [7:0] smt_mon_tol(input logic [1:0] code);
        case (code)
            2'h0: smt_mon_tol = SMT_TOL_2P0;
            2'h1: smt_mon_tol = SMT_TOL_3P0;
            2'h2: smt_mon_tol = SMT_TOL_4P0;
            default: smt_mon_tol = SMT_TOL_6P0;
        endcase
    endfunction : smt_mon_tol

    function automatic logic [11:0] smt_mon_level(input logic [2:0] code);
        case (code)
            3'h0: smt_mon_level = SMT_LVL_650MV;
            3'h1: smt_mon_level = SMT_LVL_800MV;
            3'h2: smt_mon_level = SMT_LVL_1000MV;
            3'h3: smt_mon_level = SMT_LVL_1100MV;
            3'h4: smt_mon_level = SMT_LVL_1200MV;
            3'h5: smt_mon_level = SMT_LVL_1300MV;
            3'h6: smt_mon_level = SMT_LVL_1800MV;
            default: smt_mon_level = SMT_LVL_UNDEF;
        endcase
    endfunction : smt_mon_level

    function automatic logic [6:0] smt_step_tol(input logic [1:0] code);
        case (code)
            2'h0: smt_step_tol = SMT_STEP_TOL_30MV;
            2'h1: smt_step_tol = SMT_STEP_TOL_50MV;
            2'h2: smt_step_tol = SMT_STEP_TOL_70MV;
            default: smt_step_tol = SMT_STEP_TOL_90MV;
        endcase
    endfunction : smt_step_tol

endpackage : smt_pkg

// ---- hw/smt_mon_decode.sv ----
`timescale 1ns/1ns

module smt_mon_decode
    import smt_pkg::*;
(
    input wire logic [1:0] tol_code,
    input wire logic [2:0] level_code,
    output logic [7:0] tolerance,
    output logic [11:0] level,
    output logic div_en
);

    always_comb begin
        tolerance = smt_mon_tol(tol_code);
        level = smt_mon_level(level_code);
        // code 0 keeps the pin high impedance for an external divider
        div_en = (level_code != 3'h0);
    end

endmodule : smt_mon_decode

// ---- hw/smt_threshold_regs.sv ----
`timescale 1ns/1ns

// Function
// - three level registers at 14h, reset zero
// - first monitor tolerance: 2,3,4,6 percent
// - first monitor nominal level codes 0-6
// - nonzero level code enables internal divider
// - analog tolerance: 4,5,10,10 percent
// - analog level bit: 3.3 or 5.0 V
// - second monitor tolerance, same coding
// - second monitor nominal level, same coding
// - boost tolerance: 2,4,6,8 percent
// - second step-down window 30-90 mV
// - first step-down window 30-90 mV
// - mode bit: undervoltage only or both
module smt_threshold_regs
    import smt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic otp_load,
    input wire logic [7:0] otp_cfg_a,
    input wire logic [7:0] otp_cfg_b,
    input wire logic [7:0] otp_cfg_c,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    input wire logic window_check_mode,
    output logic [7:0] ext_mon_a_tolerance,
    output logic [11:0] ext_mon_a_level,
    output logic ext_mon_a_div_en,
    output logic [7:0] ext_mon_b_tolerance,
    output logic [11:0] ext_mon_b_level,
    output logic ext_mon_b_div_en,
    output logic [7:0] analog_supply_tolerance,
    output logic [12:0] analog_supply_level,
    output logic [7:0] boost_tolerance,
    output logic [1:0] boost_level_code,
    output logic [6:0] stepdown_a_tolerance,
    output logic [6:0] stepdown_b_tolerance,
    output logic under_check_en,
    output logic over_check_en
);

    // register state
    logic [7:0] cfg_a_ff;
    logic [7:0] cfg_b_ff;
    logic [7:0] cfg_c_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_cfg_a;
    logic [7:0] nxt_cfg_b;
    logic [7:0] nxt_cfg_c;
    logic [7:0] nxt_rd_data;

    // decoded reference state
    logic [7:0] mon_a_tol_ff;
    logic [11:0] mon_a_lvl_ff;
    logic mon_a_div_ff;
    logic [7:0] mon_b_tol_ff;
    logic [11:0] mon_b_lvl_ff;
    logic mon_b_div_ff;
    logic [7:0] ana_tol_ff;
    logic [12:0] ana_lvl_ff;
    logic [7:0] boost_tol_ff;
    logic [1:0] boost_lvl_ff;
    logic [6:0] step_a_tol_ff;
    logic [6:0] step_b_tol_ff;
    logic over_en_ff;
    logic [7:0] nxt_mon_a_tol;
    logic [11:0] nxt_mon_a_lvl;
    logic nxt_mon_a_div;
    logic [7:0] nxt_mon_b_tol;
    logic [11:0] nxt_mon_b_lvl;
    logic nxt_mon_b_div;
    logic [7:0] nxt_ana_tol;
    logic [12:0] nxt_ana_lvl;
    logic [7:0] nxt_boost_tol;
    logic [1:0] nxt_boost_lvl;
    logic [6:0] nxt_step_a_tol;
    logic [6:0] nxt_step_b_tol;
    logic nxt_over_en;

    logic [7:0] dec_a_tol;
    logic [11:0] dec_a_lvl;
    logic dec_a_div;
    logic [7:0] dec_b_tol;
    logic [11:0] dec_b_lvl;
    logic dec_b_div;

    // register file: otp load beats a host write in the same cycle,
    // so with ce high the programmed defaults always land intact
    always_comb begin
        nxt_cfg_a = cfg_a_ff;
        nxt_cfg_b = cfg_b_ff;
        nxt_cfg_c = cfg_c_ff;
        nxt_rd_data = rd_data_ff;
        if (ce) begin
            if (otp_load) begin
                nxt_cfg_a = otp_cfg_a;
                nxt_cfg_b = otp_cfg_b;
                nxt_cfg_c = otp_cfg_c;
            end else if (reg_wr_en) begin
                case (reg_addr)
                    SMT_OFS_CFG_A: nxt_cfg_a = reg_wr_data;
                    SMT_OFS_CFG_B: nxt_cfg_b = reg_wr_data;
                    SMT_OFS_CFG_C: nxt_cfg_c = reg_wr_data;
                    default: nxt_cfg_a = cfg_a_ff;
                endcase
            end
            if (reg_rd_en) begin
                case (reg_addr)
                    SMT_OFS_CFG_A: nxt_rd_data = cfg_a_ff;
                    SMT_OFS_CFG_B: nxt_rd_data = cfg_b_ff;
                    SMT_OFS_CFG_C: nxt_rd_data = cfg_c_ff;
                    default: nxt_rd_data = SMT_RD_UNMAPPED;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_a_ff <= SMT_CFG_RESET;
            cfg_b_ff <= SMT_CFG_RESET;
            cfg_c_ff <= SMT_CFG_RESET;
            rd_data_ff <= SMT_RD_UNMAPPED;
        end else begin
            cfg_a_ff <= nxt_cfg_a;
            cfg_b_ff <= nxt_cfg_b;
            cfg_c_ff <= nxt_cfg_c;
            rd_data_ff <= nxt_rd_data;
        end
    end

    smt_mon_decode u_mon_a (
        .tol_code(cfg_a_ff[SMT_MON_TOL_LSB +: 2]),
        .level_code(cfg_a_ff[SMT_MON_LVL_LSB +: 3]),
        .tolerance(dec_a_tol),
        .level(dec_a_lvl),
        .div_en(dec_a_div)
    );

    smt_mon_decode u_mon_b (
        .tol_code(cfg_b_ff[SMT_MON_TOL_LSB +: 2]),
        .level_code(cfg_b_ff[SMT_MON_LVL_LSB +: 3]),
        .tolerance(dec_b_tol),
        .level(dec_b_lvl),
        .div_en(dec_b_div)
    );

    // references are registered: one extra cycle of latency buys
    // glitch-free comparator inputs while a field is rewritten
    always_comb begin
        nxt_mon_a_tol = mon_a_tol_ff;
        nxt_mon_a_lvl = mon_a_lvl_ff;
        nxt_mon_a_div = mon_a_div_ff;
        nxt_mon_b_tol = mon_b_tol_ff;
        nxt_mon_b_lvl = mon_b_lvl_ff;
        nxt_mon_b_div = mon_b_div_ff;
        nxt_ana_tol = ana_tol_ff;
        nxt_ana_lvl = ana_lvl_ff;
        nxt_boost_tol = boost_tol_ff;
        nxt_boost_lvl = boost_lvl_ff;
        nxt_step_a_tol = step_a_tol_ff;
        nxt_step_b_tol = step_b_tol_ff;
        nxt_over_en = over_en_ff;
        if (ce) begin
            nxt_mon_a_tol = dec_a_tol;
            nxt_mon_a_lvl = dec_a_lvl;
            nxt_mon_a_div = dec_a_div;
            nxt_mon_b_tol = dec_b_tol;
            nxt_mon_b_lvl = dec_b_lvl;
            nxt_mon_b_div = dec_b_div;
            case (cfg_b_ff[SMT_ANA_TOL_LSB +: 2])
                2'h0: nxt_ana_tol = SMT_TOL_4P0;
                2'h1: nxt_ana_tol = SMT_TOL_5P0;
                default: nxt_ana_tol = SMT_TOL_10P0;
            endcase
            nxt_ana_lvl = cfg_b_ff[SMT_ANA_LVL_BIT] ? SMT_ANA_5000MV : SMT_ANA_3300MV;
            case (cfg_c_ff[SMT_BOOST_TOL_LSB +: 2])
                2'h0: nxt_boost_tol = SMT_TOL_2P0;
                2'h1: nxt_boost_tol = SMT_TOL_4P0;
                2'h2: nxt_boost_tol = SMT_TOL_6P0;
                default: nxt_boost_tol = SMT_TOL_8P0;
            endcase
            // meaning of the boost code is left to the comparator side
            nxt_boost_lvl = cfg_c_ff[SMT_BOOST_LVL_LSB +: 2];
            nxt_step_b_tol = smt_step_tol(cfg_c_ff[SMT_STEPB_TOL_LSB +: 2]);
            nxt_step_a_tol = smt_step_tol(cfg_c_ff[SMT_STEPA_TOL_LSB +: 2]);
            nxt_over_en = window_check_mode;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mon_a_tol_ff <= SMT_TOL_2P0;
            mon_a_lvl_ff <= SMT_LVL_650MV;
            mon_a_div_ff <= 1'h0;
            mon_b_tol_ff <= SMT_TOL_2P0;
            mon_b_lvl_ff <= SMT_LVL_650MV;
            mon_b_div_ff <= 1'h0;
            ana_tol_ff <= SMT_TOL_4P0;
            ana_lvl_ff <= SMT_ANA_3300MV;
            boost_tol_ff <= SMT_TOL_2P0;
            boost_lvl_ff <= 2'h0;
            step_a_tol_ff <= SMT_STEP_TOL_30MV;
            step_b_tol_ff <= SMT_STEP_TOL_30MV;
            over_en_ff <= 1'h0;
        end else begin
            mon_a_tol_ff <= nxt_mon_a_tol;
            mon_a_lvl_ff <= nxt_mon_a_lvl;
            mon_a_div_ff <= nxt_mon_a_div;
            mon_b_tol_ff <= nxt_mon_b_tol;
            mon_b_lvl_ff <= nxt_mon_b_lvl;
            mon_b_div_ff <= nxt_mon_b_div;
            ana_tol_ff <= nxt_ana_tol;
            ana_lvl_ff <= nxt_ana_lvl;
            boost_tol_ff <= nxt_boost_tol;
            boost_lvl_ff <= nxt_boost_lvl;
            step_a_tol_ff <= nxt_step_a_tol;
            step_b_tol_ff <= nxt_step_b_tol;
            over_en_ff <= nxt_over_en;
        end
    end

    assign reg_rd_data = rd_data_ff;
    assign ext_mon_a_tolerance = mon_a_tol_ff;
    assign ext_mon_a_level = mon_a_lvl_ff;
    assign ext_mon_a_div_en = mon_a_div_ff;
    assign ext_mon_b_tolerance = mon_b_tol_ff;
    assign ext_mon_b_level = mon_b_lvl_ff;
    assign ext_mon_b_div_en = mon_b_div_ff;
    assign analog_supply_tolerance = ana_tol_ff;
    assign analog_supply_level = ana_lvl_ff;
    assign boost_tolerance = boost_tol_ff;
    assign boost_level_code = boost_lvl_ff;
    assign stepdown_a_tolerance = step_a_tol_ff;
    assign stepdown_b_tolerance = step_b_tol_ff;
    // undervoltage is always checked; overvoltage only in window mode
    assign under_check_en = 1'h1;
    assign over_check_en = over_en_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_host_write_a;
        (ce && reg_wr_en && !otp_load && reg_addr == SMT_OFS_CFG_A)
            |=> cfg_a_ff == $past(reg_wr_data);
    endproperty
    a_host_write_a: assert property (p_host_write_a) else $error("cfg a write lost");

    property p_otp_load;
        (ce && otp_load) |=> (cfg_b_ff == $past(otp_cfg_b)) && (cfg_c_ff == $past(otp_cfg_c));
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("otp default not loaded");

    property p_mon_a_tol;
        (ce && reg_wr_en && !otp_load && reg_addr == SMT_OFS_CFG_A
            && reg_wr_data[SMT_MON_TOL_LSB +: 2] == 2'h3)
            ##1 ce |=> ext_mon_a_tolerance == SMT_TOL_6P0;
    endproperty
    a_mon_a_tol: assert property (p_mon_a_tol) else $error("monitor a tolerance wrong");

    property p_mon_a_lvl;
        (ce && reg_wr_en && !otp_load && reg_addr == SMT_OFS_CFG_A
            && reg_wr_data[SMT_MON_LVL_LSB +: 3] == 3'h6)
            ##1 ce |=> ext_mon_a_level == SMT_LVL_1800MV && ext_mon_a_div_en;
    endproperty
    a_mon_a_lvl: assert property (p_mon_a_lvl) else $error("monitor a level wrong");

    property p_div_en;
        ce |=> ext_mon_b_div_en == ($past(cfg_b_ff[SMT_MON_LVL_LSB +: 3]) != 3'h0);
    endproperty
    a_div_en: assert property (p_div_en) else $error("divider enable mismatch");

    property p_ana;
        (ce && cfg_b_ff[SMT_ANA_TOL_LSB + 1] && cfg_b_ff[SMT_ANA_LVL_BIT])
            |=> analog_supply_tolerance == SMT_TOL_10P0
            && analog_supply_level == SMT_ANA_5000MV;
    endproperty
    a_ana: assert property (p_ana) else $error("analog reference wrong");

    property p_boost_tol;
        (ce && cfg_c_ff[SMT_BOOST_TOL_LSB +: 2] == 2'h1) |=> boost_tolerance == SMT_TOL_4P0;
    endproperty
    a_boost_tol: assert property (p_boost_tol) else $error("boost tolerance wrong");

    property p_step;
        (ce && cfg_c_ff[SMT_STEPB_TOL_LSB +: 2] == 2'h1
            && cfg_c_ff[SMT_STEPA_TOL_LSB +: 2] == 2'h2)
            |=> stepdown_b_tolerance == SMT_STEP_TOL_50MV
            && stepdown_a_tolerance == SMT_STEP_TOL_70MV;
    endproperty
    a_step: assert property (p_step) else $error("step-down window wrong");

    property p_read_c;
        (ce && reg_rd_en && reg_addr == SMT_OFS_CFG_C) |=> reg_rd_data == $past(cfg_c_ff);
    endproperty
    a_read_c: assert property (p_read_c) else $error("cfg c readback wrong");

    property p_mode;
        ce |=> over_check_en == $past(window_check_mode);
    endproperty
    a_mode: assert property (p_mode) else $error("window mode not followed");

endmodule : smt_threshold_regs

// ---- testbench/supply_monitor_threshold_regs_tb.sv ----
`timescale 1ns/1ns

module supply_monitor_threshold_regs_tb;
    import smt_pkg::*;

    localparam logic [7:0] MON_TOL [4] = '{8'h14, 8'h1E, 8'h28, 8'h3C};
    localparam logic [7:0] ANA_TOL [4] = '{8'h28, 8'h32, 8'h64, 8'h64};
    localparam logic [7:0] BST_TOL [4] = '{8'h14, 8'h28, 8'h3C, 8'h50};
    localparam logic [6:0] STP_TOL [4] = '{7'h1E, 7'h32, 7'h46, 7'h5A};
    localparam logic [11:0] MON_LVL [8] = '{12'h28A, 12'h320, 12'h3E8, 12'h44C,
        12'h4B0, 12'h514, 12'h708, 12'h000};

    logic clk;
    logic resetn;
    logic ce;
    logic otp_load;
    logic [7:0] otp_cfg_a;
    logic [7:0] otp_cfg_b;
    logic [7:0] otp_cfg_c;
    logic [7:0] reg_addr;
    logic reg_wr_en;
    logic [7:0] reg_wr_data;
    logic reg_rd_en;
    logic [7:0] reg_rd_data;
    logic window_check_mode;
    logic [7:0] ext_mon_a_tolerance;
    logic [11:0] ext_mon_a_level;
    logic ext_mon_a_div_en;
    logic [7:0] ext_mon_b_tolerance;
    logic [11:0] ext_mon_b_level;
    logic ext_mon_b_div_en;
    logic [7:0] analog_supply_tolerance;
    logic [12:0] analog_supply_level;
    logic [7:0] boost_tolerance;
    logic [1:0] boost_level_code;
    logic [6:0] stepdown_a_tolerance;
    logic [6:0] stepdown_b_tolerance;
    logic under_check_en;
    logic over_check_en;
    int bad_count;
    int n_checks;
    logic [2:0] ia;
    logic [1:0] ib;

    smt_threshold_regs smt_threshold_regs_i (
        .clk(clk), .resetn(resetn), .ce(ce), .otp_load(otp_load),
        .otp_cfg_a(otp_cfg_a), .otp_cfg_b(otp_cfg_b), .otp_cfg_c(otp_cfg_c),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .window_check_mode(window_check_mode),
        .ext_mon_a_tolerance(ext_mon_a_tolerance), .ext_mon_a_level(ext_mon_a_level),
        .ext_mon_a_div_en(ext_mon_a_div_en), .ext_mon_b_tolerance(ext_mon_b_tolerance),
        .ext_mon_b_level(ext_mon_b_level), .ext_mon_b_div_en(ext_mon_b_div_en),
        .analog_supply_tolerance(analog_supply_tolerance),
        .analog_supply_level(analog_supply_level), .boost_tolerance(boost_tolerance),
        .boost_level_code(boost_level_code), .stepdown_a_tolerance(stepdown_a_tolerance),
        .stepdown_b_tolerance(stepdown_b_tolerance), .under_check_en(under_check_en),
        .over_check_en(over_check_en)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // every driver task starts and ends just after a rising edge
    task automatic tick();
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        otp_load = 1'b0;
        @(posedge clk);
        #1;
    endtask : tick

    // enable left high so back-to-back writes never toggle it in one step
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b1;
        reg_addr = addr;
        reg_wr_data = data;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        reg_addr = addr;
        @(posedge clk);
        #1;
        chk(reg_rd_data, exp);
    endtask : rd

    // decode of an all-zero register set
    task automatic refs_zero();
        chk(reg_rd_data, 8'h00);
        chk(ext_mon_a_tolerance, 8'h14);
        chk(ext_mon_a_level, 12'h28A);
        chk({ext_mon_a_div_en, ext_mon_b_div_en}, 2'b00);
        chk(analog_supply_tolerance, 8'h28);
        chk(analog_supply_level, 13'h0CE4);
        chk(boost_tolerance, 8'h14);
        chk({stepdown_a_tolerance, stepdown_b_tolerance}, {7'h1E, 7'h1E});
        chk(over_check_en, 1'b0);
    endtask : refs_zero

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        bad_count = 0;
        n_checks = 0;
        resetn = 1'b0;
        ce = 1'b1;
        otp_load = 1'b0;
        otp_cfg_a = 8'h00;
        otp_cfg_b = 8'h00;
        otp_cfg_c = 8'h00;
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
        window_check_mode = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        refs_zero();
        tick();
        rd(SMT_OFS_CFG_A, 8'h00);
        rd(SMT_OFS_CFG_B, 8'h00);
        rd(SMT_OFS_CFG_C, 8'h00);
        // every code of every field, all three registers back to back
        for (int i = 0; i < 8; i++) begin
            ia = 3'(i);
            ib = 2'(i);
            wr(SMT_OFS_CFG_A, {ia, ib, ia});
            wr(SMT_OFS_CFG_B, {ib, ia[0], ib, ia});
            wr(SMT_OFS_CFG_C, {ib, ib, ib, ~ib});
            tick();
            chk(ext_mon_a_tolerance, MON_TOL[ib]);
            chk(ext_mon_a_level, MON_LVL[ia]);
            chk(ext_mon_a_div_en, ia != 3'h0);
            chk(ext_mon_b_div_en, ia != 3'h0);
            chk(analog_supply_tolerance, ANA_TOL[ib]);
            chk(analog_supply_level, ia[0] ? 13'h1388 : 13'h0CE4);
            chk(ext_mon_b_tolerance, MON_TOL[ib]);
            chk(ext_mon_b_level, MON_LVL[ia]);
            chk(boost_tolerance, BST_TOL[ib]);
            chk(stepdown_b_tolerance, STP_TOL[ib]);
            chk(stepdown_a_tolerance, STP_TOL[~ib]);
            chk(boost_level_code, ib);
            rd(SMT_OFS_CFG_A, {ia, ib, ia});
            rd(SMT_OFS_CFG_B, {ib, ia[0], ib, ia});
            rd(SMT_OFS_CFG_C, {ib, ib, ib, ~ib});
        end
        // unmapped neighbours neither store nor disturb the bank
        wr(8'h13, 8'h5A);
        wr(8'h17, 8'hA5);
        rd(8'h13, 8'h00);
        rd(8'h17, 8'h00);
        rd(SMT_OFS_CFG_A, 8'hFF);
        rd(SMT_OFS_CFG_C, 8'hFC);
        // frozen clock enable drops a write
        ce = 1'b0;
        wr(SMT_OFS_CFG_A, 8'h00);
        ce = 1'b1;
        tick();
        rd(SMT_OFS_CFG_A, 8'hFF);
        // default load wins over a host write in the same cycle
        otp_cfg_a = 8'h2B;
        otp_cfg_b = 8'hC6;
        otp_cfg_c = 8'h9D;
        otp_load = 1'b1;
        wr(SMT_OFS_CFG_A, 8'h11);
        tick();
        chk(ext_mon_a_level, 12'h44C);
        chk(analog_supply_tolerance, 8'h64);
        rd(SMT_OFS_CFG_A, 8'h2B);
        rd(SMT_OFS_CFG_B, 8'hC6);
        rd(SMT_OFS_CFG_C, 8'h9D);
        // mode follows one cycle later
        window_check_mode = 1'b1;
        tick();
        chk(over_check_en, 1'b1);
        chk(under_check_en, 1'b1);
        window_check_mode = 1'b0;
        tick();
        chk(over_check_en, 1'b0);
        // second reset in mid-run clears everything at once
        resetn = 1'b0;
        #2;
        refs_zero();
        @(posedge clk);
        #1;
        resetn = 1'b1;
        tick();
        rd(SMT_OFS_CFG_B, 8'h00);
        wrap_up();
    end

endmodule : supply_monitor_threshold_regs_tb
